// file: logic/dwp_debug_port.sv
// Device end of the two-wire debug and programming port.
`timescale 1ns/1ns
module dwp_debug_port (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic debug_serial_clock_in,
  output logic debug_serial_clock_out,
  output logic debug_serial_clock_oe_n,
  input wire logic debug_serial_data_in,
  output logic debug_serial_data_out,
  output logic debug_serial_data_oe_n,
  output logic mem_req,
  output logic mem_we,
  output logic [1:0] mem_space,
  output logic [15:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [7:0] mem_rdata,
  input wire logic cpu_fetch_valid,
  input wire logic [15:0] cpu_fetch_addr,
  input wire logic cpu_break_instr,
  input wire logic cpu_step_done,
  output logic cpu_halt
);
  logic [7:0] rx_byte;
  logic rx_parity_ok;
  logic rx_toggle;
  logic scl_s1, scl_s2, scl_d;
  logic sda_s1, sda_s2, sda_d;
  logic tog_s1, tog_s2, tog_d;
  logic frame_reg;
  logic [3:0] cnt_reg;
  dwp_pkg::dwp_state_t st_reg;
  logic [7:0] cmd_reg;
  logic [15:0] addr_reg;
  logic [15:0] bp_addr_reg;
  logic bp_en_reg, step_mode_reg;
  logic ack_due_reg;
  logic [7:0] tx_byte_reg;
  logic tx_ready_reg;
  logic sda_oe_n_next, scl_oe_n_next;
  logic start_evt, stop_evt, scl_rise, byte_evt, byte_ok;
  logic tx_bit, host_ack_evt, host_nak, rd_issue, wr_issue, ctrl_wr;
  logic bp_hit, halt_set;

  // The receive shifter runs on the host's clock while a frame is open.
  dwp_link_rx u_rx (
    .link_clk(debug_serial_clock_in),
    .rst_n(rst_n),
    .frame_rst_n(frame_reg),
    .sda(debug_serial_data_in),
    .rx_byte(rx_byte),
    .rx_parity_ok(rx_parity_ok),
    .rx_toggle(rx_toggle)
  );

  // Pins and the byte toggle enter this domain through two flip-flops.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      scl_s1 <= 1'b1;
      scl_s2 <= 1'b1;
      scl_d <= 1'b1;
      sda_s1 <= 1'b1;
      sda_s2 <= 1'b1;
      sda_d <= 1'b1;
      tog_s1 <= 1'b0;
      tog_s2 <= 1'b0;
      tog_d <= 1'b0;
    end else begin
      scl_s1 <= debug_serial_clock_in;
      scl_s2 <= scl_s1;
      scl_d <= scl_s2;
      sda_s1 <= debug_serial_data_in;
      sda_s2 <= sda_s1;
      sda_d <= sda_s2;
      tog_s1 <= rx_toggle;
      tog_s2 <= tog_s1;
      tog_d <= tog_s2;
    end
  end

  // Data moving while the clock stays high marks a start or a stop.
  assign start_evt = scl_s2 && scl_d && sda_d && !sda_s2; // R14
  assign stop_evt = scl_s2 && scl_d && !sda_d && sda_s2; // R14
  assign scl_rise = scl_s2 && !scl_d && frame_reg;
  assign byte_evt = (tog_s2 != tog_d) && frame_reg &&
    (st_reg != dwp_pkg::ST_TX);
  assign byte_ok = byte_evt && rx_parity_ok;
  assign host_ack_evt = scl_rise && (cnt_reg == dwp_pkg::BIT_LAST) &&
    (st_reg == dwp_pkg::ST_TX) && !ack_due_reg;
  assign host_nak = host_ack_evt && sda_s2;
  assign rd_issue = (byte_ok && (st_reg == dwp_pkg::ST_ALO) &&
    (cmd_reg[7:4] == dwp_pkg::CMD_READ)) || (host_ack_evt && !sda_s2);
  assign wr_issue = byte_ok && (st_reg == dwp_pkg::ST_WDATA);
  assign ctrl_wr = byte_ok && (st_reg == dwp_pkg::ST_CTRL);

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      frame_reg <= 1'b0;
    end else if (start_evt) begin
      frame_reg <= 1'b1; // R8
    end else if (stop_evt) begin
      frame_reg <= 1'b0; // R8
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_reg <= dwp_pkg::BIT_FIRST;
    end else if (start_evt) begin
      cnt_reg <= dwp_pkg::BIT_FIRST;
    end else if (scl_rise) begin
      if (cnt_reg == dwp_pkg::BIT_LAST) begin
        cnt_reg <= dwp_pkg::BIT_FIRST; // R7
      end else begin
        cnt_reg <= cnt_reg + 4'h1; // R1
      end
    end
  end

  // Command decoding; a bad packet or a refused acknowledge waits for a start or stop.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= dwp_pkg::ST_CMD;
      cmd_reg <= dwp_pkg::BYTE_RST;
    end else if (start_evt || stop_evt) begin
      st_reg <= dwp_pkg::ST_CMD; // R8
    end else if (host_nak) begin
      st_reg <= dwp_pkg::ST_ERR; // R5
    end else if (byte_evt && !rx_parity_ok) begin
      st_reg <= dwp_pkg::ST_ERR; // R4
    end else if (byte_evt) begin
      case (st_reg)
        dwp_pkg::ST_CMD: begin
          cmd_reg <= rx_byte;
          case (rx_byte[7:4])
            dwp_pkg::CMD_WRITE, dwp_pkg::CMD_READ, dwp_pkg::CMD_BRKPT: begin
              st_reg <= dwp_pkg::ST_AHI;
            end
            dwp_pkg::CMD_CTRL: begin
              st_reg <= dwp_pkg::ST_CTRL;
            end
            default: begin
              st_reg <= dwp_pkg::ST_ERR;
            end
          endcase
        end
        dwp_pkg::ST_AHI: begin
          st_reg <= dwp_pkg::ST_ALO;
        end
        dwp_pkg::ST_ALO: begin
          case (cmd_reg[7:4])
            dwp_pkg::CMD_WRITE: begin
              st_reg <= dwp_pkg::ST_WDATA;
            end
            dwp_pkg::CMD_READ: begin
              st_reg <= dwp_pkg::ST_TX; // R11
            end
            default: begin
              st_reg <= dwp_pkg::ST_CMD;
            end
          endcase
        end
        dwp_pkg::ST_CTRL: begin
          st_reg <= dwp_pkg::ST_CMD;
        end
        default: begin
          st_reg <= st_reg;
        end
      endcase
    end
  end

  // Address of the access in progress, advanced after each byte.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      addr_reg <= dwp_pkg::ADDR_RST;
      bp_addr_reg <= dwp_pkg::ADDR_RST;
    end else if (byte_ok && st_reg == dwp_pkg::ST_AHI) begin
      addr_reg[15:8] <= rx_byte;
    end else if (byte_ok && st_reg == dwp_pkg::ST_ALO) begin
      if (cmd_reg[7:4] == dwp_pkg::CMD_READ) begin
        addr_reg <= {addr_reg[15:8], rx_byte} + 16'h0001;
      end else begin
        addr_reg[7:0] <= rx_byte;
      end
      if (cmd_reg[7:4] == dwp_pkg::CMD_BRKPT) begin
        bp_addr_reg <= {addr_reg[15:8], rx_byte};
      end
    end else if (wr_issue || rd_issue) begin
      addr_reg <= addr_reg + 16'h0001;
    end
  end

  // Memory request holds until the system answers it.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_space <= dwp_pkg::SPACE_DATA;
      mem_addr <= dwp_pkg::ADDR_RST;
      mem_wdata <= dwp_pkg::BYTE_RST;
    end else if (wr_issue || rd_issue) begin
      mem_req <= 1'b1; // R12
      mem_we <= wr_issue;
      mem_space <= cmd_reg[1:0];
      mem_addr <= (rd_issue && st_reg == dwp_pkg::ST_ALO) ?
        {addr_reg[15:8], rx_byte} : addr_reg;
      mem_wdata <= rx_byte;
    end else if (mem_ack) begin
      mem_req <= 1'b0;
    end
  end

  // Read data waits here until the host clocks it out.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_byte_reg <= dwp_pkg::BYTE_RST;
      tx_ready_reg <= 1'b0;
    end else if (!frame_reg || rd_issue) begin
      tx_ready_reg <= 1'b0;
    end else if (mem_req && mem_ack && !mem_we) begin
      tx_byte_reg <= mem_rdata; // R12
      tx_ready_reg <= 1'b1;
    end
  end

  // Acknowledge is owed for a good packet until the tenth clock rises.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      ack_due_reg <= 1'b0;
    end else if (byte_ok && st_reg != dwp_pkg::ST_ERR) begin
      ack_due_reg <= 1'b1; // R4
    end else if (!frame_reg ||
                 (scl_rise && cnt_reg == dwp_pkg::BIT_LAST)) begin
      ack_due_reg <= 1'b0;
    end
  end

  assign tx_bit = (cnt_reg == dwp_pkg::BIT_PARITY) ? ^tx_byte_reg :
    tx_byte_reg[dwp_pkg::DATA_MSB - cnt_reg[2:0]]; // R3

  // The data line is only pulled low and only moves while the clock is low.
  always_comb begin
    sda_oe_n_next = debug_serial_data_oe_n;
    if (!frame_reg) begin
      sda_oe_n_next = 1'b1;
    end else if (!scl_s2) begin // R14
      if (cnt_reg == dwp_pkg::BIT_LAST) begin
        sda_oe_n_next = !ack_due_reg; // R4
      end else if (st_reg == dwp_pkg::ST_TX && tx_ready_reg) begin
        sda_oe_n_next = tx_bit; // R11
      end else begin
        sda_oe_n_next = 1'b1;
      end
    end
  end

  // The clock is held low only until the first bit of read data stands.
  always_comb begin
    scl_oe_n_next = 1'b1;
    if (frame_reg && st_reg == dwp_pkg::ST_TX && !scl_s2 &&
        cnt_reg == dwp_pkg::BIT_FIRST &&
        (!tx_ready_reg || debug_serial_data_oe_n != tx_bit)) begin
      scl_oe_n_next = 1'b0; // R15
    end
  end

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      debug_serial_data_oe_n <= 1'b1;
      debug_serial_clock_oe_n <= 1'b1;
      debug_serial_data_out <= 1'b0;
      debug_serial_clock_out <= 1'b0;
    end else begin
      debug_serial_data_oe_n <= sda_oe_n_next; // R9
      debug_serial_clock_oe_n <= scl_oe_n_next; // R10
      debug_serial_data_out <= 1'b0; // R9
      debug_serial_clock_out <= 1'b0; // R10
    end
  end

  // Halt control; a break event in the cycle of a run request wins.
  assign bp_hit = cpu_fetch_valid && bp_en_reg &&
    (cpu_fetch_addr == bp_addr_reg);
  assign halt_set = (ctrl_wr && rx_byte[dwp_pkg::CTRL_HALT]) ||
    cpu_break_instr || (cpu_step_done && step_mode_reg) || bp_hit; // R13

  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cpu_halt <= 1'b0;
      bp_en_reg <= 1'b0;
      step_mode_reg <= 1'b0;
    end else begin
      if (halt_set) begin
        cpu_halt <= 1'b1; // R13
      end else if (ctrl_wr && rx_byte[dwp_pkg::CTRL_RUN]) begin
        cpu_halt <= 1'b0;
      end
      if (ctrl_wr) begin
        bp_en_reg <= rx_byte[dwp_pkg::CTRL_BPEN];
        step_mode_reg <= rx_byte[dwp_pkg::CTRL_STEP];
      end
    end
  end

  property p_frame_start;
    @(posedge sys_clk) disable iff (!rst_n)
    start_evt |=> frame_reg && cnt_reg == dwp_pkg::BIT_FIRST;
  endproperty
  a_frame_start: assert property (p_frame_start) // R8
    else $error("Start did not open a frame.");

  property p_frame_stop;
    @(posedge sys_clk) disable iff (!rst_n)
    stop_evt |=> !frame_reg ##1 debug_serial_data_oe_n;
  endproperty
  a_frame_stop: assert property (p_frame_stop) // R8
    else $error("Stop did not close the frame and free the line.");

  property p_nak_error;
    @(posedge sys_clk) disable iff (!rst_n)
    (host_nak && !start_evt && !stop_evt) |=> st_reg == dwp_pkg::ST_ERR;
  endproperty
  a_nak_error: assert property (p_nak_error) // R5
    else $error("Acknowledge high did not enter error handling.");

  property p_ack_only_good;
    @(posedge sys_clk) disable iff (!rst_n)
    (byte_evt && !rx_parity_ok) |=> !ack_due_reg;
  endproperty
  a_ack_only_good: assert property (p_ack_only_good) // R4
    else $error("Acknowledge given to a bad packet.");

  property p_move_clock_low;
    @(posedge sys_clk) disable iff (!rst_n)
    (frame_reg && $changed(debug_serial_data_oe_n)) |-> !$past(scl_s2);
  endproperty
  a_move_clock_low: assert property (p_move_clock_low) // R14
    else $error("Data line moved while the clock was high.");

  property p_clock_hold;
    @(posedge sys_clk) disable iff (!rst_n)
    !debug_serial_clock_oe_n |-> $past(st_reg) == dwp_pkg::ST_TX &&
      !debug_serial_clock_out;
  endproperty
  a_clock_hold: assert property (p_clock_hold) // R10
    else $error("Clock line pulled outside a read wait.");

  property p_drive_reason;
    @(posedge sys_clk) disable iff (!rst_n)
    !debug_serial_data_oe_n |-> $past(frame_reg) &&
      ($past(st_reg) == dwp_pkg::ST_TX || $past(ack_due_reg) ||
       ($past(cnt_reg) == dwp_pkg::BIT_FIRST && $past(scl_s2)));
  endproperty
  a_drive_reason: assert property (p_drive_reason) // R11
    else $error("Data line driven with nothing to send.");

  property p_req_held;
    @(posedge sys_clk) disable iff (!rst_n)
    (mem_req && !mem_ack) |=> mem_req && $stable(mem_addr);
  endproperty
  a_req_held: assert property (p_req_held) // R12
    else $error("Memory request dropped before its answer.");

  property p_bp_halt;
    @(posedge sys_clk) disable iff (!rst_n)
    bp_hit |=> cpu_halt;
  endproperty
  a_bp_halt: assert property (p_bp_halt) // R13
    else $error("Breakpoint fetch did not halt.");

  property p_tx_parity;
    @(posedge sys_clk) disable iff (!rst_n)
    (frame_reg && st_reg == dwp_pkg::ST_TX && tx_ready_reg && !scl_s2 &&
     cnt_reg == dwp_pkg::BIT_PARITY) |=>
    debug_serial_data_oe_n == ^tx_byte_reg;
  endproperty
  a_tx_parity: assert property (p_tx_parity) // R3
    else $error("Sent parity is not even.");
endmodule : dwp_debug_port

// file: logic/dwp_link_rx.sv
// Receive shifter clocked by the debug serial clock.
`timescale 1ns/1ns
module dwp_link_rx (
  input wire logic link_clk,
  input wire logic rst_n,
  input wire logic frame_rst_n,
  input wire logic sda,
  output logic [7:0] rx_byte,
  output logic rx_parity_ok,
  output logic rx_toggle
);
  logic [3:0] cnt_reg;
  logic [7:0] shift_reg;

  // Bit position is held at the first bit while no frame is open and wraps per packet.
  always_ff @(posedge link_clk or negedge frame_rst_n) begin
    if (!frame_rst_n) begin
      cnt_reg <= dwp_pkg::BIT_FIRST;
    end else if (cnt_reg == dwp_pkg::BIT_LAST) begin
      cnt_reg <= dwp_pkg::BIT_FIRST; // R7
    end else begin
      cnt_reg <= cnt_reg + 4'h1; // R1
    end
  end

  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      shift_reg <= dwp_pkg::BYTE_RST;
    end else begin
      shift_reg <= {shift_reg[6:0], sda};
    end
  end

  // The byte and its check are handed over with a toggle on the parity bit.
  always_ff @(posedge link_clk or negedge rst_n) begin
    if (!rst_n) begin
      rx_byte <= dwp_pkg::BYTE_RST;
      rx_parity_ok <= 1'b0;
      rx_toggle <= 1'b0;
    end else if (cnt_reg == dwp_pkg::BIT_PARITY) begin
      rx_byte <= shift_reg; // R2
      rx_parity_ok <= ~(^{shift_reg, sda}); // R3
      rx_toggle <= ~rx_toggle;
    end
  end

  property p_cnt_range;
    @(posedge link_clk) disable iff (!frame_rst_n)
    cnt_reg <= dwp_pkg::BIT_LAST;
  endproperty
  a_cnt_range: assert property (p_cnt_range) // R1
    else $error("Bit position left the packet.");

  property p_byte_handover;
    @(posedge link_clk) disable iff (!frame_rst_n || !rst_n)
    (cnt_reg == dwp_pkg::BIT_PARITY) |=> $changed(rx_toggle) &&
      (rx_parity_ok == ~(^{$past(shift_reg), $past(sda)}));
  endproperty
  a_byte_handover: assert property (p_byte_handover) // R2
    else $error("Byte not handed over on the parity bit.");
endmodule : dwp_link_rx

// file: logic/dwp_pkg.sv
// Shared constants and types of the two-wire debug port.
// Summary of operation
// R1 - Each transfer is a packet of ten bit periods, one per serial clock.
// R2 - A packet is eight data bits, one parity bit, then an acknowledge bit.
// R3 - The transmitter sets parity so the nine bits hold an even count of ones.
// R4 - The receiver pulls the acknowledge low only for an error-free packet.
// R5 - A transmitter that sees acknowledge high on clock ten handles an error.
// R6 - After an acknowledge error the host stops and resends the whole command.
// R7 - A debug command is several packets between one start and one stop.
// R8 - Start and stop conditions frame each command and reset its decoding.
// R9 - Both lines are open drain, so either side can pull a line low.
// R10 - The device only pulls the serial clock low and never drives it high.
// R11 - The device drives the data line only to return data or acknowledge.
// R12 - Commands read and write data memory, peripherals, the PC and flash.
// R13 - Execution halts on a break opcode, a single step or a breakpoint.
// R14 - Data changes only while the clock is low; start and stop otherwise.
// R15 - While busy the device holds the clock low and the host waits; the device holds it only at the first bit of a read byte.
package dwp_pkg;
  localparam logic [3:0] BIT_PARITY = 4'h8;
  localparam logic [3:0] BIT_LAST = 4'h9;
  localparam logic [3:0] BIT_FIRST = 4'h0;
  localparam logic [2:0] DATA_MSB = 3'h7;
  localparam logic [3:0] CMD_WRITE = 4'h1;
  localparam logic [3:0] CMD_READ = 4'h2;
  localparam logic [3:0] CMD_CTRL = 4'h3;
  localparam logic [3:0] CMD_BRKPT = 4'h4;
  localparam int CTRL_HALT = 0;
  localparam int CTRL_STEP = 1;
  localparam int CTRL_BPEN = 2;
  localparam int CTRL_RUN = 3;
  localparam logic [1:0] SPACE_DATA = 2'h0;
  localparam logic [1:0] SPACE_PERIPH = 2'h1;
  localparam logic [1:0] SPACE_PC = 2'h2;
  localparam logic [1:0] SPACE_FLASH = 2'h3;
  localparam logic [15:0] ADDR_RST = 16'h0000;
  localparam logic [7:0] BYTE_RST = 8'h00;
  typedef enum logic [2:0] {
    ST_CMD = 3'h0,
    ST_AHI = 3'h1,
    ST_ALO = 3'h2,
    ST_WDATA = 3'h3,
    ST_TX = 3'h4,
    ST_CTRL = 3'h5,
    ST_ERR = 3'h6
  } dwp_state_t;
endpackage : dwp_pkg

// file: testbench/dwp_host_model.sv
// Behavioural debug host driving the open-drain two-wire link.
`timescale 1ns/1ns
module dwp_host_model (
  input wire logic scl_line,
  input wire logic sda_line,
  output logic scl_drv,
  output logic sda_drv
);
  initial begin
    scl_drv = 1'b1;
    sda_drv = 1'b1;
  end
  // One bit period; the bit is sampled late in the high phase.
  task automatic bit_cycle(input logic b, output logic seen);
    int n;
    n = 0;
    scl_drv = 1'b0;
    #16 sda_drv = b;
    #16 scl_drv = 1'b1;
    while (scl_line !== 1'b1 && n < 4000) begin
      #4 n++;
    end
    #32 seen = sda_line;
  endtask : bit_cycle
  task automatic send_byte(input logic [7:0] d, input logic flip,
                           output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--) bit_cycle(d[i], s);
    bit_cycle((^d) ^ flip, s);
    bit_cycle(1'b1, ack);
  endtask : send_byte
  task automatic recv_byte(input logic host_ack, output logic [7:0] d,
                           output logic par_ok);
    logic s;
    for (int i = 7; i >= 0; i--) begin
      bit_cycle(1'b1, s);
      d[i] = s;
    end
    bit_cycle(1'b1, s);
    par_ok = ((^d) === s);
    bit_cycle(host_ack, s);
  endtask : recv_byte
  task automatic start_cond();
    scl_drv = 1'b1;
    #67 sda_drv = 1'b0;
    #48;
  endtask : start_cond
  task automatic stop_cond();
    scl_drv = 1'b0;
    #16 sda_drv = 1'b0;
    #16 scl_drv = 1'b1;
    #32 sda_drv = 1'b1;
    #64;
  endtask : stop_cond
endmodule : dwp_host_model

// file: testbench/tb_dwp_debug_port.sv
// Self-checking bench for the two-wire debug port.
`timescale 1ns/1ns
module tb_dwp_debug_port;
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic scl_drv;
  logic sda_drv;
  wire logic scl_line;
  wire logic sda_line;
  logic scl_out;
  logic scl_oe_n;
  logic sda_out;
  logic sda_oe_n;
  logic mem_req;
  logic mem_we;
  logic [1:0] mem_space;
  logic [15:0] mem_addr;
  logic [7:0] mem_wdata;
  logic mem_ack = 1'b0;
  logic [7:0] mem_rdata = 8'h00;
  logic cpu_fetch_valid = 1'b0;
  logic [15:0] cpu_fetch_addr = 16'h0000;
  logic cpu_break_instr = 1'b0;
  logic cpu_step_done = 1'b0;
  logic cpu_halt;
  logic clk_high_seen = 1'b0;
  logic [26:0] req_q[$];
  int seed = 32'h4FAF;
  int wcnt = 0;
  int cyc = 0;
  int num_errors = 0;
  int tests_run = 0;
  logic [15:0] a;
  logic [7:0] d[2];
  logic [7:0] rd;
  logic pok;
  logic ack;

  always #5 sys_clk = ~sys_clk;
  assign scl_line = scl_drv & (scl_oe_n | scl_out);
  assign sda_line = sda_drv & (sda_oe_n | sda_out);

  dwp_host_model host_u (.scl_line(scl_line), .sda_line(sda_line),
    .scl_drv(scl_drv), .sda_drv(sda_drv));

  dwp_debug_port dut_u (.sys_clk(sys_clk), .rst_n(rst_n),
    .debug_serial_clock_in(scl_line), .debug_serial_clock_out(scl_out),
    .debug_serial_clock_oe_n(scl_oe_n), .debug_serial_data_in(sda_line),
    .debug_serial_data_out(sda_out), .debug_serial_data_oe_n(sda_oe_n),
    .mem_req(mem_req), .mem_we(mem_we), .mem_space(mem_space),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .cpu_fetch_valid(cpu_fetch_valid),
    .cpu_fetch_addr(cpu_fetch_addr), .cpu_break_instr(cpu_break_instr),
    .cpu_step_done(cpu_step_done), .cpu_halt(cpu_halt));

  function automatic logic [7:0] pat(input logic [1:0] s,
                                     input logic [15:0] ad);
    return ad[7:0] ^ ad[15:8] ^ {6'h15, s};
  endfunction : pat

  // Memory model answering each request after 1 to 8 cycles.
  always @(posedge sys_clk) begin
    mem_ack <= 1'b0;
    if (!scl_oe_n && scl_out !== 1'b0) clk_high_seen <= 1'b1;
    if (mem_req === 1'b1 && !mem_ack) begin
      if (wcnt == 0) wcnt = 1 + ($unsigned($random(seed)) % 8);
      wcnt--;
      if (wcnt == 0) begin
        mem_ack <= 1'b1;
        mem_rdata <= pat(mem_space, mem_addr);
        if (mem_we) req_q.push_back({1'b1, mem_space, mem_addr, mem_wdata});
      end
    end
  end

  task automatic check_val(input string nm, input logic [26:0] exp,
                           input logic [26:0] got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, exp, got);
    end
  endtask : check_val

  task automatic check_bit(input string nm, input logic exp,
                           input logic got);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %s expected %b seen %b", nm, exp, got);
    end
  endtask : check_bit

  task automatic cmd(input logic [7:0] q[$], input logic fin);
    logic k;
    host_u.start_cond();
    foreach (q[i]) begin
      host_u.send_byte(q[i], 1'b0, k);
      check_bit("ack", 1'b0, k);
    end
    if (fin) host_u.stop_cond();
  endtask : cmd

  task automatic ctrl(input logic [7:0] b, input logic exp);
    cmd('{{dwp_pkg::CMD_CTRL, 4'h0}, b}, 1'b1);
    repeat (10) @(posedge sys_clk);
    check_bit("halt", exp, cpu_halt);
  endtask : ctrl

  task automatic cpu_ev(input int k, input logic [15:0] fa, input logic exp);
    @(posedge sys_clk);
    cpu_break_instr <= (k == 0);
    cpu_step_done <= (k == 1);
    cpu_fetch_valid <= (k == 2);
    cpu_fetch_addr <= fa;
    @(posedge sys_clk);
    cpu_break_instr <= 1'b0;
    cpu_step_done <= 1'b0;
    cpu_fetch_valid <= 1'b0;
    repeat (5) @(posedge sys_clk);
    check_bit("halt", exp, cpu_halt);
  endtask : cpu_ev

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 30000) begin
      num_errors++;
      $display("BAD timeout expected 0 seen %0d", cyc);
      print_verdict();
    end
  end

  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (5) @(posedge sys_clk);
    for (int s = 0; s < 4; s++) begin
      a = 16'($random(seed));
      d[0] = 8'($random(seed));
      d[1] = 8'($random(seed));
      cmd('{{dwp_pkg::CMD_WRITE, 2'h0, 2'(s)}, a[15:8], a[7:0], d[0], d[1]},
          1'b1);
      repeat (20) @(posedge sys_clk);
      check_val("writes", 27'h2, 27'(req_q.size()));
      for (int i = 0; i < 2; i++) begin
        if (req_q.size() > 0) begin
          check_val("wr", {1'b1, 2'(s), a + 16'(i), d[i]},
                    req_q.pop_front());
        end
      end
      cmd('{{dwp_pkg::CMD_READ, 2'h0, 2'(s)}, a[15:8], a[7:0]}, 1'b0);
      for (int i = 0; i < 3; i++) begin
        host_u.recv_byte(i == 2, rd, pok);
        check_val("rd", {19'h0, pat(2'(s), a + 16'(i))}, {19'h0, rd});
        check_bit("rd parity", 1'b1, pok);
      end
      host_u.stop_cond();
      req_q.delete();
    end
    $display("test write and read done");
    host_u.start_cond();
    host_u.send_byte({dwp_pkg::CMD_WRITE, 4'h0}, 1'b1, ack);
    check_bit("bad parity ack", 1'b1, ack);
    host_u.send_byte(8'h12, 1'b0, ack);
    check_bit("ignored ack", 1'b1, ack);
    host_u.stop_cond();
    cmd('{8'h50}, 1'b1);
    repeat (20) @(posedge sys_clk);
    check_val("no writes", 27'h0, 27'(req_q.size()));
    cmd('{{dwp_pkg::CMD_WRITE, 4'h0}, 8'h12, 8'h34, 8'hA5}, 1'b1);
    repeat (20) @(posedge sys_clk);
    check_val("retry", {1'b1, 2'h0, 16'h1234, 8'hA5}, req_q[0]);
    $display("test error recovery done");
    ctrl(8'h01, 1'b1);
    ctrl(8'h09, 1'b1);
    ctrl(8'h08, 1'b0);
    cpu_ev(0, 16'h0000, 1'b1);
    ctrl(8'h0A, 1'b0);
    cpu_ev(1, 16'h0000, 1'b1);
    a = 16'($random(seed));
    cmd('{{dwp_pkg::CMD_BRKPT, 4'h0}, a[15:8], a[7:0]}, 1'b1);
    ctrl(8'h0C, 1'b0);
    cpu_ev(2, a ^ 16'h0001, 1'b0);
    cpu_ev(2, a, 1'b1);
    $display("test halt control done");
    check_bit("clock driven high", 1'b0, clk_high_seen);
    print_verdict();
  end
endmodule : tb_dwp_debug_port
